// [eac_array_ctrl.sv]
// Controller for a 768-byte byte-erasable non-volatile array with its control registers.
// Assumes one AHB-Lite master whose hready is this slave's HREADYOUT, and mode
// indications (normal, wait, stop) from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "eac_params.svh"

module eac_array_ctrl #(
  parameter int PROG_CYCLES = `EAC_PROG_CYC_DEF,
  parameter int RAMP_CYCLES = `EAC_RAMP_CYC_DEF
) (
  input  wire  logic             SYS_CLK,
  input  wire  logic             NRST,
  input  wire  logic             HSEL,
  input  wire  logic [31:0]      HADDR,
  input  wire  logic [1:0]       HTRANS,
  input  wire  logic             HWRITE,
  input  wire  logic [2:0]       HSIZE,
  input  wire  logic [31:0]      HWDATA,
  input  wire  logic             HREADY,
  output logic                   HREADYOUT,
  output logic [31:0]            HRDATA,
  output logic                   HRESP,
  input  wire  logic             NORMAL_MODE,
  input  wire  logic             WAIT_MODE,
  input  wire  logic             STOP_MODE,
  output eac_pkg::eac_pump_t     PUMP,
  output logic                   MODULE_CLK_RUN
);
  import eac_pkg::*;

  localparam int WORDS = `EAC_ARRAY_BYTES / 2;

  // ==========================================================================
  // Parameter checks: both counters are EAC_CNT_W bits wide
  if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << `EAC_CNT_W)) begin : g_bad_prog
    $error("PROG_CYCLES out of range");
  end
  if (RAMP_CYCLES < 1 || RAMP_CYCLES >= (1 << `EAC_CNT_W)) begin : g_bad_ramp
    $error("RAMP_CYCLES out of range");
  end

  localparam logic [`EAC_CNT_W-1:0] PROG_LAST = (`EAC_CNT_W)'(PROG_CYCLES - 1);
  localparam logic [`EAC_CNT_W-1:0] RAMP_LAST = (`EAC_CNT_W)'(RAMP_CYCLES - 1);
  localparam logic [8:0]            WORD_LAST = 9'(WORDS - 1);

  // ==========================================================================
  // Storage
  logic [15:0] mem [WORDS];
  logic        mem_we;
  logic [8:0]  mem_idx;
  logic [15:0] mem_wdata;

  eac_state_t  s;
  eac_state_t  next_s;

  // ==========================================================================
  // Decoding helpers
  function automatic logic in_array(input logic [15:0] a);
    in_array = (a >= `EAC_ARRAY_BASE) && (a <= `EAC_ARRAY_LAST);
  endfunction : in_array

  function automatic logic [7:0] arr_byte(input logic [15:0] a);
    logic [15:0] off;
    off = a - `EAC_ARRAY_BASE;
    arr_byte = off[0] ? mem[off[9:1]][15:8] : mem[off[9:1]][7:0];
  endfunction : arr_byte

  // Region guard by byte offset into the array
  function automatic logic is_protected(input logic [8:0] w, input logic [4:0] prot);
    logic [9:0] off;
    off = {w, 1'b0};
    if (off < `EAC_REG3_START)
      is_protected = prot[4];
    else if (off < `EAC_REG2_START)
      is_protected = prot[3];
    else if (off < `EAC_REG1_START)
      is_protected = prot[2];
    else if (off < `EAC_REG0_START)
      is_protected = prot[1];
    else
      is_protected = prot[0];
  endfunction : is_protected

  function automatic logic row_hit(input logic [8:0] w, input eac_state_t st);
    logic odd_row;
    odd_row = w[`EAC_ROW_WORDS_LOG2];
    row_hit = (st.odd && odd_row) || (st.even && !odd_row);
  endfunction : row_hit

  // Which words the current operation touches
  function automatic logic word_sel(input logic [8:0] w, input eac_state_t st);
    logic hit;
    if (st.erase) begin
      if (st.byte_mode)
        hit = (w == st.lat_word);
      else if (st.bulk_erase_protect)
        hit = 1'b0;
      else if (st.row_mode)
        hit = (w[8:`EAC_ROW_WORDS_LOG2] == st.lat_word[8:`EAC_ROW_WORDS_LOG2]);
      else if (st.odd || st.even)
        hit = row_hit(w, st);
      else
        hit = 1'b1;
    end else if (st.odd || st.even) begin
      hit = row_hit(w, st);
    end else begin
      hit = (w == st.lat_word);
    end
    word_sel = hit && !is_protected(w, st.prot);
  endfunction : word_sel

  function automatic logic [31:0] bus_read(input logic [15:0] a, input logic [1:0] sz,
                                           input eac_state_t st);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `EAC_ADDR_MCR: begin
        v[`EAC_MCR_WSTOP] = st.wait_stop;
        v[`EAC_MCR_LOCK]  = st.lock;
        v[`EAC_MCR_PSEL]  = st.pump_sel;
      end
      `EAC_ADDR_PROT: v[4:0] = st.prot;
      `EAC_ADDR_TST: begin
        v[`EAC_TST_ODD]  = st.odd;
        v[`EAC_TST_EVEN] = st.even;
        v[`EAC_TST_MARGIN_TEST] = st.margin_test;
        v[`EAC_TST_CPD]  = st.cpd;
        v[`EAC_TST_CPRD] = st.cprd;
        v[`EAC_TST_CPM]  = st.cpm;
      end
      `EAC_ADDR_PROG: begin
        v[`EAC_PROG_BULK_ERASE_PROTECT] = st.bulk_erase_protect;
        v[`EAC_PROG_BYTE]  = st.byte_mode;
        v[`EAC_PROG_ROW]   = st.row_mode;
        v[`EAC_PROG_ERASE] = st.erase;
        v[`EAC_PROG_LATCH] = st.latch;
        v[`EAC_PROG_PGM]   = st.pgm;
      end
      `EAC_ADDR_INIT: v[`EAC_INIT_RDEN] = st.read_en;
      default: begin
        // Disabled or latched array lets lower-priority resources answer; here it reads zero
        if (in_array(a) && st.read_en && !st.latch) begin
          v[7:0] = arr_byte(a);
          if (sz != `EAC_SIZE_BYTE && in_array(a + 16'h0001))
            v[15:8] = arr_byte(a + 16'h0001);
        end
      end
    endcase
    bus_read = v;
  endfunction : bus_read

  // ==========================================================================
  // Next state
  always_comb begin
    logic        take;
    logic [15:0] a_in;
    logic        run;
    logic        pump_go;
    logic [15:0] off;
    logic [15:0] old_w;
    logic [15:0] dmask;
    next_s    = s;
    mem_we    = 1'b0;
    mem_idx   = s.sweep;
    mem_wdata = 16'h0000;
    off       = 16'h0000;
    take      = HSEL && HTRANS[1] && HREADY;
    a_in      = (HADDR[31:16] == 16'h0000) ? HADDR[15:0] : `EAC_ADDR_NONE;
    run       = !STOP_MODE && !(WAIT_MODE && s.wait_stop);
    pump_go   = s.pgm && run && !s.cpd;
    old_w     = mem[s.sweep];
    dmask     = {{8{s.lat_mask[1]}}, {8{s.lat_mask[0]}}};

    // Bus data phase of a write: HWDATA stands now
    next_s.wr_pend = 1'b0;
    if (s.wr_pend) begin
      unique case (s.wr_addr)
        `EAC_ADDR_MCR: begin
          next_s.pump_sel  = HWDATA[`EAC_MCR_PSEL];
          next_s.wait_stop = HWDATA[`EAC_MCR_WSTOP];
          if (!NORMAL_MODE) begin
            next_s.lock = HWDATA[`EAC_MCR_LOCK];
          end else if (!s.lock_written) begin
            next_s.lock         = HWDATA[`EAC_MCR_LOCK];
            next_s.lock_written = 1'b1;
          end
        end
        `EAC_ADDR_PROT: begin
          if (!s.pgm && !s.lock)
            next_s.prot = HWDATA[4:0];
        end
        `EAC_ADDR_TST: begin
          if (!NORMAL_MODE) begin
            next_s.odd  = HWDATA[`EAC_TST_ODD];
            next_s.even = HWDATA[`EAC_TST_EVEN];
            next_s.margin_test = HWDATA[`EAC_TST_MARGIN_TEST];
            next_s.cpd  = HWDATA[`EAC_TST_CPD];
            next_s.cprd = HWDATA[`EAC_TST_CPRD];
            next_s.cpm  = HWDATA[`EAC_TST_CPM];
          end
        end
        `EAC_ADDR_PROG: begin
          if (!s.pgm) begin
            if (!s.lock)
              next_s.bulk_erase_protect = HWDATA[`EAC_PROG_BULK_ERASE_PROTECT];
            next_s.byte_mode = HWDATA[`EAC_PROG_BYTE];
            next_s.row_mode  = HWDATA[`EAC_PROG_ROW];
            next_s.erase     = HWDATA[`EAC_PROG_ERASE];
            next_s.latch     = HWDATA[`EAC_PROG_LATCH];
            next_s.pgm       = HWDATA[`EAC_PROG_PGM] && s.latch;
          end else begin
            // Only the closing write may drop the latch together with the enable
            next_s.pgm = HWDATA[`EAC_PROG_PGM];
            if (!HWDATA[`EAC_PROG_PGM])
              next_s.latch = HWDATA[`EAC_PROG_LATCH];
          end
        end
        `EAC_ADDR_INIT: next_s.read_en = HWDATA[`EAC_INIT_RDEN];
        default: begin
          if (in_array(s.wr_addr) && s.latch && !s.pgm) begin
            off             = s.wr_addr - `EAC_ARRAY_BASE;
            next_s.lat_word = off[9:1];
            if (s.wr_size == `EAC_SIZE_BYTE || off[0]) begin
              // Misaligned word keeps just the byte at its own address
              next_s.lat_mask = off[0] ? 2'h2 : 2'h1;
              next_s.lat_data = off[0] ? {HWDATA[7:0], 8'h00} : {8'h00, HWDATA[7:0]};
            end else begin
              next_s.lat_mask = 2'h3;
              next_s.lat_data = HWDATA[15:0];
            end
          end
        end
      endcase
    end
    if (!next_s.latch)
      next_s.lat_mask = 2'h0;
    if (NORMAL_MODE) begin
      next_s.odd  = 1'b0;
      next_s.even = 1'b0;
      next_s.margin_test = 1'b0;
      next_s.cpd  = 1'b0;
      next_s.cprd = 1'b0;
      next_s.cpm  = 1'b0;
    end

    // Bus address phase and read answers
    if (s.rd_pend) begin
      next_s.hrdata  = bus_read(s.rd_addr, s.rd_size, next_s);
      next_s.hready  = 1'b1;
      next_s.rd_pend = 1'b0;
    end
    if (take) begin
      if (HWRITE) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_addr = a_in;
        next_s.wr_size = HSIZE[1:0];
      end else if (s.wr_pend || (HSIZE[1:0] != `EAC_SIZE_BYTE && HADDR[0])) begin
        // One wait state: misaligned word, or a read right behind a write
        next_s.rd_pend = 1'b1;
        next_s.rd_addr = a_in;
        next_s.rd_size = HSIZE[1:0];
        next_s.hready  = 1'b0;
      end else begin
        next_s.hrdata = bus_read(a_in, HSIZE[1:0], s);
      end
    end

    // Program and erase engine, frozen whenever the module clock is off
    if (run) begin
      unique case (s.phase)
        PH_IDLE: begin
          next_s.ramp_cnt = '0;
          if (s.pgm)
            next_s.phase = PH_RAMP;
        end
        PH_RAMP: begin
          if (!s.pgm) begin
            next_s.phase = PH_IDLE;
          end else if (pump_go) begin
            if (s.cprd || s.ramp_cnt == RAMP_LAST) begin
              next_s.phase    = PH_TIMING;
              next_s.prog_cnt = '0;
            end else begin
              next_s.ramp_cnt = s.ramp_cnt + 1'b1;
            end
          end
        end
        PH_TIMING: begin
          if (!s.pgm) begin
            next_s.phase = PH_IDLE;
          end else if (pump_go) begin
            if (s.prog_cnt == PROG_LAST) begin
              next_s.phase = PH_SWEEP;
              next_s.sweep = '0;
            end else begin
              next_s.prog_cnt = s.prog_cnt + 1'b1;
            end
          end
        end
        PH_SWEEP: begin
          if (!s.pgm) begin
            next_s.phase = PH_IDLE;
          end else begin
            if (word_sel(s.sweep, s)) begin
              mem_we = 1'b1;
              if (s.erase)
                mem_wdata = old_w | (s.byte_mode ? dmask : 16'hffff);
              else
                mem_wdata = old_w & (s.lat_data | ~dmask);
            end
            next_s.sweep = s.sweep + 1'b1;
            if (s.sweep == WORD_LAST)
              next_s.phase = PH_DONE;
          end
        end
        PH_DONE: begin
          if (!s.pgm)
            next_s.phase = PH_IDLE;
        end
      endcase
    end

    // Pump controls: stop drops voltage and RC clock, enable bit itself stays
    next_s.pump.hv_on     = pump_go;
    next_s.pump.hv_full   = pump_go && (s.phase == PH_TIMING || s.phase == PH_SWEEP);
    next_s.pump.rc_select = s.pump_sel;
    next_s.pump.rc_run    = s.pump_sel && run;
    next_s.pump.monitor   = s.cpm;
    next_s.pump.margin    = s.margin_test;
    next_s.clk_run        = run;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      s           <= '0;
      s.hready    <= 1'b1;
      s.prot      <= `EAC_PROT_RESET;
      s.bulk_erase_protect     <= `EAC_BULK_ERASE_PROTECT_RESET;
      s.read_en   <= `EAC_RDEN_RESET;
      s.phase     <= PH_IDLE;
      s.clk_run   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Array cells carry no reset: contents are non-volatile
  always_ff @(posedge SYS_CLK) begin
    if (mem_we)
      mem[mem_idx] <= mem_wdata;
  end

  assign HREADYOUT      = s.hready;
  assign HRDATA         = s.hrdata;
  assign HRESP          = 1'b0;
  assign PUMP           = s.pump;
  assign MODULE_CLK_RUN = s.clk_run;

endmodule : eac_array_ctrl
`default_nettype wire

// [eac_params.svh]
// Constants for the non-volatile array controller: addresses, field positions,
// reset values and default operation lengths.
// Assumes a byte-addressed AHB-Lite map with one aligned word per control register.
//
// ==========================================================================
`ifndef EAC_PARAMS_SVH
`define EAC_PARAMS_SVH

// ==========================================================================
// Address map
`define EAC_ADDR_MCR       16'h00f0
`define EAC_ADDR_PROT      16'h00f4
`define EAC_ADDR_TST       16'h00f8
`define EAC_ADDR_PROG      16'h00fc
`define EAC_ADDR_INIT      16'h00e0
`define EAC_ARRAY_BASE     16'h0d00
`define EAC_ARRAY_LAST     16'h0fff
`define EAC_ADDR_NONE      16'hffff
`define EAC_ARRAY_BYTES    768
`define EAC_ROW_WORDS_LOG2 4

// ==========================================================================
// Protected region starts, as byte offsets into the array
`define EAC_REG3_START     10'h100
`define EAC_REG2_START     10'h200
`define EAC_REG1_START     10'h280
`define EAC_REG0_START     10'h2c0

// ==========================================================================
// Field positions
`define EAC_MCR_WSTOP      2
`define EAC_MCR_LOCK       1
`define EAC_MCR_PSEL       0
`define EAC_PROG_BULK_ERASE_PROTECT     7
`define EAC_PROG_BYTE      4
`define EAC_PROG_ROW       3
`define EAC_PROG_ERASE     2
`define EAC_PROG_LATCH     1
`define EAC_PROG_PGM       0
`define EAC_TST_ODD        7
`define EAC_TST_EVEN       6
`define EAC_TST_MARGIN_TEST       5
`define EAC_TST_CPD        4
`define EAC_TST_CPRD       3
`define EAC_TST_CPM        2
`define EAC_INIT_RDEN      0

// ==========================================================================
// Reset values and defaults
`define EAC_PROT_RESET     5'h1f
`define EAC_BULK_ERASE_PROTECT_RESET    1'b1
`define EAC_RDEN_RESET     1'b1
`define EAC_PROG_CYC_DEF   1000
`define EAC_RAMP_CYC_DEF   100
`define EAC_CNT_W          16
`define EAC_SIZE_BYTE      2'h0

`endif

// [eac_pkg.sv]
// Types for the non-volatile array controller.
// Assumes eac_params.svh is on the include path.
`default_nettype none
`include "eac_params.svh"

package eac_pkg;

  // ==========================================================================
  // Operation engine phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_RAMP,
    PH_TIMING,
    PH_SWEEP,
    PH_DONE
  } eac_phase_t;

  // ==========================================================================
  // Charge pump and clock controls leaving the block
  typedef struct packed {
    logic hv_on;
    logic hv_full;
    logic rc_select;
    logic rc_run;
    logic monitor;
    logic margin;
  } eac_pump_t;

  // ==========================================================================
  // Whole controller state
  typedef struct packed {
    logic                  hready;
    logic [31:0]           hrdata;
    logic                  wr_pend;
    logic [15:0]           wr_addr;
    logic [1:0]            wr_size;
    logic                  rd_pend;
    logic [15:0]           rd_addr;
    logic [1:0]            rd_size;
    logic                  wait_stop;
    logic                  lock;
    logic                  lock_written;
    logic                  pump_sel;
    logic [4:0]            prot;
    logic                  bulk_erase_protect;
    logic                  byte_mode;
    logic                  row_mode;
    logic                  erase;
    logic                  latch;
    logic                  pgm;
    logic                  odd;
    logic                  even;
    logic                  margin_test;
    logic                  cpd;
    logic                  cprd;
    logic                  cpm;
    logic                  read_en;
    logic [8:0]            lat_word;
    logic [15:0]           lat_data;
    logic [1:0]            lat_mask;
    logic [`EAC_CNT_W-1:0] ramp_cnt;
    logic [`EAC_CNT_W-1:0] prog_cnt;
    logic [8:0]            sweep;
    eac_phase_t            phase;
    eac_pump_t             pump;
    logic                  clk_run;
  } eac_state_t;

endpackage : eac_pkg
`default_nettype wire

// [eac_array_ctrl_props.sv]
// Port checker for the non-volatile array controller.
// Assumes only the top module's ports; bound into every controller instance.
`timescale 1ns/100ps
`default_nettype none

module eac_array_ctrl_chk
  import eac_pkg::*;
(
  input wire logic               SYS_CLK,
  input wire logic               NRST,
  input wire logic               HSEL,
  input wire logic [31:0]        HADDR,
  input wire logic [1:0]         HTRANS,
  input wire logic               HWRITE,
  input wire logic [2:0]         HSIZE,
  input wire logic               HREADY,
  input wire logic               HREADYOUT,
  input wire logic               HRESP,
  input wire logic               STOP_MODE,
  input wire logic               WAIT_MODE,
  input wire eac_pkg::eac_pump_t PUMP,
  input wire logic               MODULE_CLK_RUN
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  // ========
  // Bus timing
  sequence rd_take;
    HSEL && HTRANS[1] && HREADY && !HWRITE;
  endsequence
  sequence one_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  // A byte read right after a write's address phase may be waited, so skip that case
  sequence rd_byte_clean;
    rd_take and (HSIZE == 3'h0) && !$past(HSEL && HTRANS[1] && HWRITE);
  endsequence

  misalign_wait_a : assert property (rd_take and HADDR[0] && HSIZE != 3'h0 |=> one_wait)
    else $error("misaligned read not waited one cycle");
  byte_fast_a : assert property (rd_byte_clean |=> HREADYOUT)
    else $error("byte read was waited");
  wait_once_a : assert property ($fell(HREADYOUT) |=> HREADYOUT)
    else $error("wait state longer than one cycle");
  resp_okay_a : assert property (HRESP == 1'b0)
    else $error("error response seen");

  // ========
  // Pump and clock
  stop_hv_off_a : assert property (STOP_MODE |=> !PUMP.hv_on)
    else $error("high voltage on during stop");
  stop_clk_off_a : assert property (STOP_MODE |=> !MODULE_CLK_RUN)
    else $error("module clock runs during stop");
  run_clk_on_a : assert property (!STOP_MODE && !WAIT_MODE |=> MODULE_CLK_RUN)
    else $error("module clock gated outside low power");
  full_needs_on_a : assert property (PUMP.hv_full |-> PUMP.hv_on)
    else $error("full voltage without pump on");
  rc_run_sel_a : assert property (PUMP.rc_run |-> PUMP.rc_select && MODULE_CLK_RUN)
    else $error("oscillator runs while not selected");
endmodule : eac_array_ctrl_chk

bind eac_array_ctrl eac_array_ctrl_chk u_chk (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .STOP_MODE(STOP_MODE), .WAIT_MODE(WAIT_MODE), .PUMP(PUMP),
  .MODULE_CLK_RUN(MODULE_CLK_RUN)
);
`default_nettype wire

// [eac_cpu_model.sv]
// CPU bus master model: single AHB-Lite transfers through one task.
// Assumes the slave's HREADYOUT is fed back as hready.
`timescale 1ns/100ps
`default_nettype none

module eac_cpu_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h0;
    hwdata = 32'h0;
  end

  // Called right after a rising edge; to is set if the slave never answers
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [2:0] sz,
                      input logic [31:0] wd, output logic [31:0] rd, output bit to);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {16'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= sz;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    to = (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    to = to || (n >= 100);
  endtask : xfer
endmodule : eac_cpu_model
`default_nettype wire

// [eac_array_ctrl_tb.sv]
// Self-checking bench for the non-volatile array controller.
// Assumes the package, the controller, its checker and the bus model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module eac_array_ctrl_tb;
  import eac_pkg::*;
  logic        sys_clk, nrst, normal_mode, wait_mode, stop_mode;
  logic        hsel, hwrite, hreadyout, hresp, clk_run;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  eac_pump_t   pump;
  int          fails, n_checks;

  eac_array_ctrl #(.PROG_CYCLES(4), .RAMP_CYCLES(2)) dut (
    .SYS_CLK(sys_clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .NORMAL_MODE(normal_mode),
    .WAIT_MODE(wait_mode), .STOP_MODE(stop_mode), .PUMP(pump), .MODULE_CLK_RUN(clk_run));
  eac_cpu_model u_cpu (
    .clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ========
  // Tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [15:0] a, input logic [2:0] sz,
                      input logic [31:0] d, output logic [31:0] r);
    bit to;
    u_cpu.xfer(w, a, sz, d, r, to);
    if (to) begin
      fails++;
      $display("[FAIL] bus answer at %h expected ready seen none", a);
      finish_test();
    end
  endtask : xfer

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [2:0] sz = 3'h2);
    logic [31:0] r;
    xfer(1'b1, a, sz, d, r);
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input logic [2:0] sz = 3'h2);
    logic [31:0] r;
    xfer(1'b0, a, sz, 32'h0, r);
    check($sformatf("read %h", a), exp, r);
  endtask : rdc

  // Latch, load one location, apply voltage, wait out the whole sweep, close
  task automatic run_op(input logic [7:0] ctl, input logic [15:0] a, input logic [15:0] d);
    wr(16'h00fc, {24'h0, ctl | 8'h02});
    wr(a, {16'h0, d}, 3'h1);
    wr(16'h00fc, {24'h0, ctl | 8'h03});
    repeat (500) @(posedge sys_clk);
    wr(16'h00fc, 32'h0);
  endtask : run_op

  // ========
  // Tests
  initial begin
    fails = 0;
    n_checks = 0;
    nrst = 1'b0;
    normal_mode = 1'b0;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rdc(16'h00f0, 32'h00);
    rdc(16'h00f4, 32'h1f);
    rdc(16'h00fc, 32'h80);
    rdc(16'h00e0, 32'h01);
    wr(16'h00f8, 32'h24);
    rdc(16'h00f8, 32'h24);
    check("pump test", 32'h3, {30'h0, pump.monitor, pump.margin});
    normal_mode <= 1'b1;
    wr(16'h00f8, 32'h24);
    rdc(16'h00f8, 32'h00);
    normal_mode <= 1'b0;
    $display("test registers done");
    wr(16'h00f4, 32'h00);
    run_op(8'h04, 16'h0d00, 16'h0000);
    rdc(16'h0fff, 32'hff, 3'h0);
    run_op(8'h00, 16'h0d00, 16'h1234);
    rdc(16'h0d01, 32'hff12, 3'h1);
    rdc(16'h0d00, 32'h34, 3'h0);
    run_op(8'h84, 16'h0d00, 16'h0000);
    rdc(16'h0d00, 32'h1234, 3'h1);
    run_op(8'h94, 16'h0d00, 16'h0000);
    rdc(16'h0d00, 32'hffff, 3'h1);
    wr(16'h00f4, 32'h10);
    run_op(8'h00, 16'h0d02, 16'h0000);
    rdc(16'h0d02, 32'hffff, 3'h1);
    $display("test array done");
    wr(16'h00fc, 32'h03);
    rdc(16'h00fc, 32'h02);
    rdc(16'h0d00, 32'h0, 3'h1);
    wr(16'h00fc, 32'h00);
    wr(16'h00e0, 32'h00);
    rdc(16'h0d00, 32'h0, 3'h1);
    rdc(16'h00f4, 32'h10);
    wr(16'h00e0, 32'h01);
    wr(16'h00fc, 32'h02);
    wr(16'h0e00, 32'h00ff, 3'h1);
    wr(16'h00f0, 32'h01);
    wr(16'h00fc, 32'h03);
    wait_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("wait run", 32'h3, {30'h0, pump.hv_on, clk_run});
    wait_mode <= 1'b0;
    stop_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("stop", 32'h0, {30'h0, pump.hv_on, clk_run});
    stop_mode <= 1'b0;
    rdc(16'h00fc, 32'h03);
    check("stop exit", 32'h1, {31'h0, pump.hv_on});
    wr(16'h00f0, 32'h05);
    wait_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("wait gated", 32'h1, {29'h0, pump.hv_on, clk_run, pump.rc_select});
    wait_mode <= 1'b0;
    repeat (500) @(posedge sys_clk);
    wr(16'h00fc, 32'h00);
    rdc(16'h0e00, 32'h00ff, 3'h1);
    $display("test low power done");
    wr(16'h00f8, 32'h98);
    wr(16'h00fc, 32'h02);
    wr(16'h0e20, 32'h0f0f, 3'h1);
    wr(16'h00fc, 32'h03);
    repeat (3) @(posedge sys_clk);
    check("pump disabled", 32'h0, {31'h0, pump.hv_on});
    wr(16'h00f8, 32'h88);
    repeat (3) @(posedge sys_clk);
    check("ramp skipped", 32'h1, {31'h0, pump.hv_full});
    repeat (500) @(posedge sys_clk);
    wr(16'h00fc, 32'h00);
    rdc(16'h0e60, 32'h0f0f, 3'h1);
    rdc(16'h0e40, 32'hffff, 3'h1);
    $display("test row bits done");
    nrst <= 1'b0;
    normal_mode <= 1'b1;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    wr(16'h00f4, 32'h01);
    rdc(16'h00f4, 32'h01);
    wr(16'h00f0, 32'h02);
    wr(16'h00f4, 32'h1f);
    rdc(16'h00f4, 32'h01);
    wr(16'h00f0, 32'h00);
    rdc(16'h00f0, 32'h02);
    wr(16'h00fc, 32'h02);
    wr(16'h0e02, 32'h5aa5, 3'h1);
    wr(16'h00fc, 32'h03);
    wr(16'h0e02, 32'h0000, 3'h1);
    repeat (500) @(posedge sys_clk);
    wr(16'h00fc, 32'h00);
    rdc(16'h0e02, 32'h5aa5, 3'h1);
    $display("test lock done");
    finish_test();
  end
endmodule : eac_array_ctrl_tb
`default_nettype wire
